// *** core/reset_powerdown_sequencer.sv ***
// reset and power-down sequencer for the microcontroller core
`timescale 1ns/10ps
`default_nettype none
module reset_powerdown_sequencer
  import pwr_seq_pkg::*;
#(
  parameter int DelayCyc = WAKE_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic resetInN,
  input wire logic nmiIn,
  input wire logic testModeN,
  input wire logic sleepRequestBit,
  input wire logic haltExec,
  input wire logic nmiTaken,
  input wire logic delayPinIn,
  output logic delayPinOut,
  output logic delayPinOe,
  output logic resetOut,
  output logic coreReset,
  output logic busAbort,
  output logic clockEnable,
  output logic sleeping,
  output logic nmiPending,
  output logic pinsFloat
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [NUM_PINS-1:0] pinRaw;
  logic [NUM_PINS-1:0] pinSync;
  logic resLow;
  logic nmiHigh;
  logic testSelN;
  logic delayCharged;

  // gather the asynchronous pins, one lane each
  always_comb begin
    pinRaw = '0;
    pinRaw[PIN_RESET] = resetInN;
    pinRaw[PIN_NMI] = nmiIn;
    pinRaw[PIN_TEST] = testModeN;
    pinRaw[PIN_DELAY] = delayPinIn;
  end

  // two flops per pin, first stage read only by the second
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_sync
    logic [1:0] stage_q;
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        stage_q <= {2{SYNC_RESET[i]}};
      end else begin
        stage_q <= {stage_q[0], pinRaw[i]};
      end
    end
    assign pinSync[i] = stage_q[1];
  end

  // synchronised levels; reset reads as asserted until proven high
  assign resLow = ~pinSync[PIN_RESET];
  assign nmiHigh = pinSync[PIN_NMI];
  assign testSelN = pinSync[PIN_TEST];
  assign delayCharged = pinSync[PIN_DELAY];

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  seq_state_t state_q;
  seq_state_t state_d;
  logic nmiLatch_q;
  wake_timer_if wt ();

  // ---------------------------------------------------------------
  // decoded events
  // ---------------------------------------------------------------
  logic sleepEntry;
  logic wakeEvent;
  logic wakeDone;
  logic resetGone;

  // halt with the request bit set is the only road into sleep
  assign sleepEntry = sleepRequestBit && haltExec;
  // a remembered nmi is the only wake source besides reset
  assign wakeEvent = nmiLatch_q;
  // timer end, only heeded in the wake state
  assign wakeDone = wt.done;
  // reset pin seen high again: leave reset at once, no delay wait
  assign resetGone = !resLow;

  // next-state logic
  always_comb begin
    state_d = state_q;
    wt.start = 1'b0;
    case (state_q)
      ST_RESET: begin
        if (resetGone) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sleepEntry) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wakeEvent) begin
          state_d = ST_WAKE;
          wt.start = 1'b1;
        end
      end
      ST_WAKE: begin
        if (wakeDone) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
    if (resLow) begin
      state_d = ST_RESET;
      wt.start = 1'b0;
    end
  end

  // state register
  // one-hot state, reset lands in the reset state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // nmi latch, set wins over the nmiTaken clear, the reset pin clear wins over set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nmiLatch_q <= 1'b0;
    end else if (resLow) begin
      nmiLatch_q <= 1'b0;
    end else if (nmiHigh) begin
      nmiLatch_q <= 1'b1;
    end else if (nmiTaken) begin
      nmiLatch_q <= 1'b0;
    end
  end

  // wake delay counter
  // every start pulse clears the count, so a wake cut by reset leaves no stale count
  wake_delay_timer #(
    .DelayCyc(DelayCyc)
  ) i_wake_delay_timer (
    .clk(clk),
    .rst(rst),
    .pinHigh(delayCharged),
    .tmr(wt)
  );

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  // reset indicator and bus abort track the reset input
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resetOut <= 1'b1;
      coreReset <= 1'b1;
      busAbort <= 1'b1;
    end else begin
      resetOut <= resLow || state_d == ST_RESET;
      coreReset <= state_d == ST_RESET;
      busAbort <= resLow;
    end
  end

  // clock gating and sleep status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clockEnable <= 1'b0;
      sleeping <= 1'b0;
      nmiPending <= 1'b0;
    end else begin
      clockEnable <= state_d == ST_RUN;
      sleeping <= state_d == ST_SLEEP || state_d == ST_WAKE;
      nmiPending <= nmiLatch_q;
    end
  end

  // test-mode float, caught while reset is active
  // the level seen last before reset lifts is kept afterwards
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinsFloat <= 1'b0;
    end else if (resLow) begin
      pinsFloat <= ~testSelN;
    end
  end

  // delay pin: driven low to discharge cap except while timing a wake
  // released only in the wake state so the capacitor can charge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      delayPinOut <= 1'b0;
      delayPinOe <= 1'b1;
    end else begin
      delayPinOut <= 1'b0;
      delayPinOe <= state_d != ST_WAKE;
    end
  end
endmodule
`default_nettype wire

// *** core/pwr_seq_pkg.sv ***
// constants and types shared by the reset and power-down sequencer
package pwr_seq_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  // default wake delay in microseconds, standing in for the capacitor
  localparam int WAKE_DELAY_US = 100;
  localparam int WAKE_DELAY_CYC = (WAKE_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W = 16;
  // ---------------------------------------------------------------
  // asynchronous pin lanes
  // ---------------------------------------------------------------
  localparam int NUM_PINS = 4;
  localparam int PIN_RESET = 0;
  localparam int PIN_NMI = 1;
  localparam int PIN_TEST = 2;
  localparam int PIN_DELAY = 3;
  // synchroniser reset levels: reset pin low, test select idle high
  localparam logic [NUM_PINS-1:0] SYNC_RESET = 4'h4;
  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET = 4'b0001,
    ST_RUN = 4'b0010,
    ST_SLEEP = 4'b0100,
    ST_WAKE = 4'b1000
  } seq_state_t;
endpackage

// *** core/wake_timer_if.sv ***
// carrier between sequencer and wake delay timer
`timescale 1ns/10ps
`default_nettype none
interface wake_timer_if;
  logic start;
  logic done;
  modport seq (output start, input done);
  modport tmr (input start, output done);
endinterface
`default_nettype wire

// *** core/wake_delay_timer.sv ***
// counts the power-down exit delay once started
`timescale 1ns/10ps
`default_nettype none
module wake_delay_timer
  import pwr_seq_pkg::*;
#(
  parameter int DelayCyc = WAKE_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pinHigh,
  wake_timer_if.tmr tmr
);
  logic [WAKE_CNT_W-1:0] count_q;
  logic running_q;

  // ---------------------------------------------------------------
  // delay counter, ends at count or when capacitor pin reads charged
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
      running_q <= 1'b0;
      tmr.done <= 1'b0;
    end else begin
      tmr.done <= 1'b0;
      if (tmr.start) begin
        count_q <= '0;
        running_q <= 1'b1;
      end else if (running_q) begin
        if (count_q == WAKE_CNT_W'(DelayCyc - 1) || pinHigh) begin
          running_q <= 1'b0;
          tmr.done <= 1'b1;
        end else begin
          count_q <= count_q + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/delay_cap_model.sv ***
// capacitor model on the wake delay pin
`timescale 1ns/10ps
`default_nettype none
module delay_cap_model #(parameter int ChargeCyc = 40) (
  input wire logic clk,
  input wire logic delayPinOut,
  input wire logic delayPinOe,
  output logic delayPinIn
);
  int charge = 0;
  // charges while released, discharged while driven
  always @(posedge clk) begin
    if (delayPinOe) charge <= 0;
    else if (charge < ChargeCyc) charge <= charge + 1;
  end
  // driven level, else high once charged
  assign delayPinIn = delayPinOe ? delayPinOut : (charge >= ChargeCyc);
endmodule
`default_nettype wire

// *** verif/reset_powerdown_sequencer_monitor.sv ***
// port assertions for the sequencer
`timescale 1ns/10ps
`default_nettype none
module reset_powerdown_sequencer_monitor #(parameter int DelayCyc = 8) (
  input wire logic clk,
  input wire logic rst,
  input wire logic resetInN,
  input wire logic nmiIn,
  input wire logic testModeN,
  input wire logic sleepRequestBit,
  input wire logic haltExec,
  input wire logic delayPinOe,
  input wire logic resetOut,
  input wire logic coreReset,
  input wire logic busAbort,
  input wire logic clockEnable,
  input wire logic sleeping,
  input wire logic nmiPending,
  input wire logic pinsFloat
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_ENTRY: assert property (haltExec && sleepRequestBit && clockEnable |=>
    sleeping && !clockEnable) else $error("sleep not entered");
  AST_GATED: assert property (sleeping |-> !clockEnable) else $error("clock on in sleep");
  AST_STAY: assert property (sleeping && !nmiPending && resetInN && !busAbort |=>
    sleeping) else $error("sleep left without cause");
  AST_WAKE: assert property ($fell(delayPinOe) |->
    !clockEnable [*8] ##[1:4] clockEnable) else $error("wake delay wrong");
  AST_ABORT: assert property ($fell(resetInN) |-> ##[1:4] busAbort && coreReset)
    else $error("reset not taken");
  AST_DEFINED: assert property (coreReset |->
    resetOut && !clockEnable && !sleeping && delayPinOe) else $error("reset levels wrong");
  AST_LATCH: assert property ($rose(nmiIn) |-> ##[1:4] nmiPending) else $error("nmi lost");
  AST_FLOAT: assert property ($fell(resetInN) && !testModeN |-> ##[2:6] pinsFloat)
    else $error("pins not floated");
  // cycles spent with the delay pin released
  int wakeCnt_q;
  always_ff @(posedge clk) begin
    wakeCnt_q <= (rst || delayPinOe) ? 0 : wakeCnt_q + 1;
  end
  AST_SPAN: assert property (wakeCnt_q <= DelayCyc + 1)
    else $error("wake delay too long");
endmodule
bind reset_powerdown_sequencer reset_powerdown_sequencer_monitor #(.DelayCyc(DelayCyc)) i_mon (
  .clk, .rst, .resetInN, .nmiIn, .testModeN, .sleepRequestBit, .haltExec, .delayPinOe,
  .resetOut, .coreReset, .busAbort, .clockEnable, .sleeping, .nmiPending, .pinsFloat);
`default_nettype wire

// *** verif/reset_powerdown_sequencer_bench.sv ***
// testbench for the reset and power-down sequencer
`timescale 1ns/10ps
`default_nettype none
module reset_powerdown_sequencer_bench;
  logic clk = 0, rst = 1, resetInN = 1, nmiIn = 0, testModeN = 1, sleepRequestBit = 0;
  logic haltExec = 0, nmiTaken = 0, delayPinIn, delayPinOut, delayPinOe, resetOut;
  logic coreReset, busAbort, clockEnable, sleeping, nmiPending, pinsFloat;
  int mismatches = 0, testsRun = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  reset_powerdown_sequencer #(.DelayCyc(8)) i_reset_powerdown_sequencer (.clk, .rst,
    .resetInN, .nmiIn, .testModeN, .sleepRequestBit, .haltExec, .nmiTaken, .delayPinIn,
    .delayPinOut, .delayPinOe, .resetOut, .coreReset, .busAbort, .clockEnable, .sleeping,
    .nmiPending, .pinsFloat);
  delay_cap_model i_delay_cap_model (.clk, .delayPinOut, .delayPinOe, .delayPinIn);
  task automatic chk(input string n, input logic e, input logic g);
    testsRun++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic hold_reset();
    cyc(10);
    chk("resetOut", 1, resetOut);
    chk("clockEnable", 0, clockEnable);
    chk("delayPinOe", 1, delayPinOe);
    chk("delayPinOut", 0, delayPinOut);
    rst = 0;
    cyc(10);
    chk("resetOut", 0, resetOut);
  endtask
  task automatic halt();
    haltExec = 1;
    cyc(1);
    haltExec = 0;
  endtask
  task automatic sleep_nmi();
    sleepRequestBit = 1;
    halt();
    chk("sleeping", 1, sleeping);
    chk("clockEnable", 0, clockEnable);
    cyc(20);
    chk("sleeping", 1, sleeping);
    nmiIn = 1;
    cyc(1);
    nmiIn = 0;
    cyc(5);
    chk("nmiPending", 1, nmiPending);
    chk("clockEnable", 0, clockEnable);
    chk("delayPinOe", 0, delayPinOe);
    chk("delayPinOut", 0, delayPinOut);
    cyc(12);
    chk("clockEnable", 1, clockEnable);
    chk("delayPinOe", 1, delayPinOe);
    nmiTaken = 1;
    cyc(1);
    nmiTaken = 0;
    sleepRequestBit = 0;
    cyc(1);
    chk("nmiPending", 0, nmiPending);
  endtask
  task automatic refuse();
    halt();
    cyc(2);
    chk("sleeping", 0, sleeping);
  endtask
  task automatic reset_sleep();
    sleepRequestBit = 1;
    halt();
    resetInN = 0;
    cyc(5);
    chk("resetOut", 1, resetOut);
    chk("busAbort", 1, busAbort);
    chk("coreReset", 1, coreReset);
    chk("sleeping", 0, sleeping);
    chk("pinsFloat", 0, pinsFloat);
    resetInN = 1;
    sleepRequestBit = 0;
    cyc(7);
    chk("clockEnable", 1, clockEnable);
  endtask
  task automatic float_pins();
    testModeN = 0;
    resetInN = 0;
    cyc(5);
    chk("pinsFloat", 1, pinsFloat);
    resetInN = 1;
    testModeN = 1;
    cyc(8);
    chk("resetOut", 0, resetOut);
  endtask
  task automatic conclude();
    $display("mismatches %0d testsRun %0d", mismatches, testsRun);
    if (mismatches == 0 && testsRun > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    hold_reset();
    sleep_nmi();
    refuse();
    reset_sleep();
    float_pins();
    conclude();
  end
  // watchdog
  initial begin
    #20us;
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
